// *** verilog/obfl_cfg.svh ***
`ifndef OBFL_CFG_SVH
`define OBFL_CFG_SVH
// Boot timing and framing
`define OBFL_STARTUP_CYC  7'd100
`define OBFL_FRAME_BITS   18'd9
`define OBFL_ACK_BYTE     8'h00
`define OBFL_SYNC_BYTE    8'h55
// Boot RAM map
`define OBFL_LOAD_BASE    24'hffe400
`define OBFL_LOAD_LAST    24'hfffb7f
`define OBFL_RSV1_LO      24'hffdc00
`define OBFL_RSV1_HI      24'hffe3ff
`define OBFL_RSV2_LO      24'hfffb80
`define OBFL_RSV2_HI      24'hfffbff
`define OBFL_LEN_RST      16'h1780
// APB map
`define OBFL_A_CTRL       12'h000
`define OBFL_A_STAT       12'h004
`define OBFL_A_BAUD       12'h008
`define OBFL_A_LEN        12'h00c
// Control bit positions
`define OBFL_B_SWE        0
`define OBFL_B_PROG       1
`define OBFL_B_ERASE      2
`endif

// *** verilog/obfl_pkg.sv ***
package obfl_pkg;
	// Boot sequencer states
	typedef enum logic [3:0] {
		ST_STARTUP = 4'h0,
		ST_MEASURE = 4'h1,
		ST_DIVIDE  = 4'h2,
		ST_ACK     = 4'h3,
		ST_SYNC    = 4'h4,
		ST_CHECK   = 4'h5,
		ST_ERASE   = 4'h6,
		ST_LOAD    = 4'h7,
		ST_BRANCH  = 4'h8,
		ST_RUN     = 4'h9,
		ST_NORMAL  = 4'ha
	} obfl_state_t;
	// Strap pins sampled at reset release
	typedef struct packed {
		logic flash_write_enable_pin;
		logic md2;
		logic md1;
		logic md0;
	} obfl_mode_t;
	// Loaded-program RAM write port
	typedef struct packed {
		logic        we;
		logic [23:0] addr;
		logic [7:0]  data;
	} obfl_ram_t;
endpackage : obfl_pkg

// *** verilog/obfl_boot.sv ***
// How it works
// [RL1] Boot mode: write enable 1, modes 01x
// [RL2] User program mode: modes 11x, write enable high
// [RL3] Measure low time of repeated zero bytes
// [RL4] Serial framing 8 data, 1 stop, no parity
// [RL5] Send one zero byte after rate found
// [RL6] Host answers 55 hex or resets
// [RL7] Host sends at 4800 or 9600 bps
// [RL8] Adjustment valid for stated clock ranges
// [RL9] Loaded program lands in FFE400 to FFFB7F
// [RL10] Boot-owned RAM kept until branch
// [RL11] Branch to start of loaded area
// [RL12] Rx high at reset; wait 100 states
// [RL13] Erase all flash if not blank
// [RL14] Stop serial, keep divisor, tx high
// [RL15] Exit: reset 20 states, new pins
// [RL16] Watchdog reset leaves boot mode
// [RL17] Board keeps pins steady in boot
// [RL18] No interrupts during program or erase
// [RL19] Flash unreadable while software enable set
// [RL20] Write enable high only when needed
// [RL21] User mode peripherals behave as normal
// [RL22] No program or erase without pin high
// [RL23] Divisor is low period over nine
// [RL24] Load sequentially, branch after count
//
// Implementation choices: the APB register port and the register addresses.
`include "obfl_cfg.svh"
module obfl_boot (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Board pins
	input  wire obfl_pkg::obfl_mode_t mode_pins,
	input  wire logic                serial_receive_pin,
	output logic                     serial_transmit_pin,
	output logic                     serial_transmit_oe_n,
	// System side
	input  wire logic                wdt_overflow_rst,
	input  wire logic                flash_blank,
	input  wire logic                flash_erase_done,
	output logic                     flash_erase_all,
	output obfl_pkg::obfl_ram_t      ram_wr,
	output logic                     boot_rsv_protect,
	output logic                     branch_go,
	output logic      [23:0]         branch_addr,
	output logic                     boot_mode,
	output logic                     user_program_mode,
	output logic                     single_chip,
	output logic                     prog_enable,
	output logic                     erase_enable,
	output logic                     flash_read_block,
	output logic                     irq_block
);
	obfl_pkg::obfl_state_t state;
	obfl_pkg::obfl_mode_t  mode_m, mode_s;
	logic        rx_m, rx_s, captured;
	logic [6:0]  start_cnt;
	logic [17:0] low_cnt, rem; // RL8
	logic [15:0] divisor, load_len, load_cnt;
	logic [2:0]  ctrl;
	logic        fwe_now;
	// Receiver and transmitter
	logic        rx_en, rx_busy, rx_valid;
	logic [15:0] rx_tmr;
	logic [3:0]  rx_bit;
	logic [7:0]  rx_sh;
	logic        tx_start, tx_busy;
	logic [15:0] tx_tmr;
	logic [3:0]  tx_bit;
	logic [9:0]  tx_sh;

	// True when an address lies in the loaded-program area
	function automatic logic in_load(input logic [23:0] a);
		in_load = (a >= `OBFL_LOAD_BASE) && (a <= `OBFL_LOAD_LAST);
	endfunction : in_load

	// Strap synchroniser runs through reset, so straps are settled at release
	always_ff @(posedge pclk)
	begin
		mode_m <= mode_pins;
		mode_s <= mode_m;
	end

	// Receive synchroniser idles high in reset, like the pulled-up line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_m <= 1'b1;
			rx_s <= 1'b1;
		end
		else
		begin
			rx_m <= serial_receive_pin;
			rx_s <= rx_m;
		end
	end
	assign fwe_now = mode_s.flash_write_enable_pin;

	// Straps caught once after reset release; watchdog clears boot
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			captured          <= 1'b0;
			boot_mode         <= 1'b0;
			user_program_mode <= 1'b0;
			single_chip       <= 1'b0;
		end
		else if (wdt_overflow_rst)
			boot_mode <= 1'b0; // RL16
		else if (!captured)
		begin
			captured          <= 1'b1;
			boot_mode         <= mode_s.flash_write_enable_pin & !mode_s.md2 & mode_s.md1; // RL1
			user_program_mode <= mode_s.flash_write_enable_pin & mode_s.md2 & mode_s.md1; // RL2
			single_chip       <= mode_s.md0; // RL1
		end
	end

	// Boot sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state     <= obfl_pkg::ST_STARTUP;
			start_cnt <= '0;
			low_cnt   <= '0;
			rem       <= '0;
			divisor   <= '0;
			load_cnt  <= '0;
		end
		else if (wdt_overflow_rst)
			state <= obfl_pkg::ST_NORMAL; // RL16
		else
		begin
			case (state)
				obfl_pkg::ST_STARTUP:
					if (start_cnt == `OBFL_STARTUP_CYC - 7'd1)
						state <= boot_mode ? obfl_pkg::ST_MEASURE : obfl_pkg::ST_NORMAL; // RL12 RL21
					else
						start_cnt <= start_cnt + 7'd1;
				obfl_pkg::ST_MEASURE:
					if (!rx_s)
						low_cnt <= low_cnt + 18'd1; // RL3
					else if (low_cnt != '0)
					begin
						rem     <= low_cnt;
						divisor <= '0;
						state   <= obfl_pkg::ST_DIVIDE;
					end
				obfl_pkg::ST_DIVIDE:
					// Repeated subtraction avoids a divider; worst case 29127 subtraction cycles
					if (rem >= `OBFL_FRAME_BITS)
					begin
						rem     <= rem - `OBFL_FRAME_BITS; // RL23
						divisor <= divisor + 16'd1;
					end
					else
						state <= obfl_pkg::ST_ACK;
				obfl_pkg::ST_ACK:
					if (tx_start)
						state <= obfl_pkg::ST_SYNC; // RL5
				obfl_pkg::ST_SYNC:
					if (rx_valid && rx_sh == `OBFL_SYNC_BYTE)
						state <= obfl_pkg::ST_CHECK; // RL6
				obfl_pkg::ST_CHECK:
					state <= flash_blank ? obfl_pkg::ST_LOAD : obfl_pkg::ST_ERASE; // RL13
				obfl_pkg::ST_ERASE:
					if (flash_erase_done)
						state <= obfl_pkg::ST_LOAD;
				obfl_pkg::ST_LOAD:
					if (rx_valid)
					begin
						load_cnt <= load_cnt + 16'd1; // RL24
						if (load_cnt == load_len - 16'd1)
							state <= obfl_pkg::ST_BRANCH;
					end
				obfl_pkg::ST_BRANCH:
					state <= obfl_pkg::ST_RUN; // RL11
				obfl_pkg::ST_RUN:
					state <= obfl_pkg::ST_RUN;
				obfl_pkg::ST_NORMAL:
					state <= obfl_pkg::ST_NORMAL;
				default:
					state <= obfl_pkg::ST_NORMAL;
			endcase
		end
	end

	// Sequencer outputs
	assign tx_start         = (state == obfl_pkg::ST_ACK) && !tx_busy;
	assign rx_en            = (state == obfl_pkg::ST_SYNC) || (state == obfl_pkg::ST_LOAD); // RL14
	assign flash_erase_all  = (state == obfl_pkg::ST_ERASE); // RL13
	assign branch_go        = (state == obfl_pkg::ST_BRANCH); // RL11
	assign branch_addr      = `OBFL_LOAD_BASE; // RL11
	assign boot_rsv_protect = boot_mode && (state != obfl_pkg::ST_RUN); // RL10

	// Loaded bytes go in order from the area base, never outside it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ram_wr <= '0;
		else
		begin
			ram_wr.we   <= (state == obfl_pkg::ST_LOAD) && rx_valid
				&& in_load(`OBFL_LOAD_BASE + {8'h00, load_cnt}); // RL9
			ram_wr.addr <= `OBFL_LOAD_BASE + {8'h00, load_cnt}; // RL24
			ram_wr.data <= rx_sh;
		end
	end

	// Receiver: 8N1, samples mid-bit with the measured divisor
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_busy  <= 1'b0;
			rx_valid <= 1'b0;
			rx_tmr   <= '0;
			rx_bit   <= '0;
			rx_sh    <= '0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (!rx_en)
				rx_busy <= 1'b0;
			else if (!rx_busy)
			begin
				if (!rx_s)
				begin
					rx_busy <= 1'b1;
					rx_tmr  <= {1'b0, divisor[15:1]};
					rx_bit  <= '0;
				end
			end
			else if (rx_tmr != '0)
				rx_tmr <= rx_tmr - 16'd1;
			else
			begin
				rx_tmr <= divisor;
				rx_bit <= rx_bit + 4'd1;
				if (rx_bit == 4'd0 && rx_s)
					rx_busy <= 1'b0; // False start
				else if (rx_bit >= 4'd1 && rx_bit <= 4'd8)
					rx_sh <= {rx_s, rx_sh[7:1]}; // RL4
				else if (rx_bit == 4'd9)
				begin
					rx_busy  <= 1'b0;
					rx_valid <= rx_s; // RL4
				end
			end
		end
	end

	// Transmitter: one frame, then line idles high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_busy <= 1'b0;
			tx_tmr  <= '0;
			tx_bit  <= '0;
			tx_sh   <= '1;
		end
		else if (tx_start)
		begin
			tx_busy <= 1'b1;
			tx_tmr  <= divisor;
			tx_bit  <= '0;
			tx_sh   <= {1'b1, `OBFL_ACK_BYTE, 1'b0}; // RL5
		end
		else if (tx_busy)
		begin
			if (tx_tmr != '0)
				tx_tmr <= tx_tmr - 16'd1;
			else
			begin
				tx_tmr <= divisor;
				tx_sh  <= {1'b1, tx_sh[9:1]};
				tx_bit <= tx_bit + 4'd1;
				if (tx_bit == 4'd9)
					tx_busy <= 1'b0;
			end
		end
	end
	// Serial stopped in RUN: pin held high as output
	assign serial_transmit_pin  = (state == obfl_pkg::ST_RUN) ? 1'b1 : tx_sh[0]; // RL14
	assign serial_transmit_oe_n = 1'b0;

	// Software control and load length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl     <= '0;
			load_len <= `OBFL_LEN_RST;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == `OBFL_A_CTRL)
				ctrl <= pwdata[2:0];
			if (paddr == `OBFL_A_LEN)
				load_len <= pwdata[15:0];
		end
	end
	// Flash gating: pin must be high for any software program or erase
	assign prog_enable      = ctrl[`OBFL_B_PROG] & ctrl[`OBFL_B_SWE] & fwe_now; // RL22
	assign erase_enable     = ctrl[`OBFL_B_ERASE] & ctrl[`OBFL_B_SWE] & fwe_now; // RL22
	assign flash_read_block = ctrl[`OBFL_B_SWE]; // RL19
	assign irq_block        = prog_enable | erase_enable | flash_erase_all; // RL18

	// APB read data latched in setup phase, answered with no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= 1'b0;
			case (paddr)
				`OBFL_A_CTRL: prdata <= {29'h0, ctrl};
				`OBFL_A_STAT: prdata <= {20'h0, state, 4'h0, single_chip,
					user_program_mode, boot_mode, fwe_now};
				`OBFL_A_BAUD: prdata <= {16'h0, divisor}; // RL14
				`OBFL_A_LEN:  prdata <= {16'h0, load_len};
				default:
				begin
					prdata  <= '0;
					pslverr <= 1'b1;
				end
			endcase
		end
	end
	assign pready = 1'b1;

	// Checks
	sequence s_load_done;
		state == obfl_pkg::ST_LOAD && rx_valid && load_cnt == load_len - 16'd1;
	endsequence
	sequence s_branch_run;
		branch_go ##1 (state == obfl_pkg::ST_RUN && !branch_go);
	endsequence
	a_branch_after_count: assert property (@(posedge pclk) disable iff (!presetn) // RL24
		s_load_done |=> s_branch_run)
		else $error("branch did not follow last byte");
	a_ram_in_area: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		ram_wr.we |-> in_load(ram_wr.addr))
		else $error("ram write outside load area");
	a_startup_wait: assert property (@(posedge pclk) disable iff (!presetn) // RL12
		$rose(captured) |-> (state == obfl_pkg::ST_STARTUP)[*8])
		else $error("measure started too early");
	a_prog_needs_pin: assert property (@(posedge pclk) disable iff (!presetn) // RL22
		(prog_enable || erase_enable) |-> mode_s.flash_write_enable_pin && ctrl[`OBFL_B_SWE])
		else $error("flash enabled without pin");
	a_irq_block: assert property (@(posedge pclk) disable iff (!presetn) // RL18
		flash_erase_all |-> irq_block)
		else $error("interrupts open during erase");
	a_tx_high_run: assert property (@(posedge pclk) disable iff (!presetn) // RL14
		state == obfl_pkg::ST_RUN |-> serial_transmit_pin && !rx_en && !serial_transmit_oe_n)
		else $error("serial not stopped after branch");
	a_wdt_exit: assert property (@(posedge pclk) disable iff (!presetn) // RL16
		wdt_overflow_rst |=> !boot_mode && state == obfl_pkg::ST_NORMAL)
		else $error("watchdog did not leave boot");
	a_ack_then_sync: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		tx_start |=> tx_busy && state == obfl_pkg::ST_SYNC && !serial_transmit_pin)
		else $error("ack frame not started");
	a_divide_nine: assert property (@(posedge pclk) disable iff (!presetn) // RL23
		state == obfl_pkg::ST_DIVIDE && rem >= `OBFL_FRAME_BITS
		|=> rem == $past(rem) - `OBFL_FRAME_BITS)
		else $error("divisor step wrong");
	a_rsv_until_run: assert property (@(posedge pclk) disable iff (!presetn) // RL10
		boot_mode && state == obfl_pkg::ST_LOAD |-> boot_rsv_protect)
		else $error("boot ram released early");
endmodule : obfl_boot

// *** bench/obfl_host_model.sv ***
module obfl_host_model
#(
	// Short bit time keeps the run brief; the measure counter also spans 4800 bps
	parameter int BIT_CYC = 48
)
(
	// Clock
	input  wire logic pclk,
	// Serial lines
	input  wire logic from_dev,
	output logic      to_dev
);
	timeunit 1ns;
	timeprecision 100ps;

	// Pulled up on the board, so idle and reset release see a high line
	initial to_dev = 1'b1;

	// One frame: start, eight data bits lsb first, one stop, no parity
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			to_dev <= f[i];
			repeat (BIT_CYC) @(posedge pclk);
		end
	endtask : send

	// Samples mid-bit; the bounded wait stops a silent device hanging us
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (from_dev !== 1'b0 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge pclk);
			b[i] = from_dev;
		end
		repeat (BIT_CYC) @(posedge pclk);
		ok = (n < 20000) && (from_dev === 1'b1);
	endtask : recv

	// Zero byte for rate finding; answer 55 only on a clean zero reply
	task automatic adjust(output logic [7:0] ack, output logic ok);
		fork
			send(8'h00);
			recv(ack, ok);
		join
		if (ok && ack === 8'h00)
			send(8'h55);
	endtask : adjust
endmodule : obfl_host_model

// *** bench/test_onboard_flash_boot_loader.sv ***
`include "obfl_cfg.svh"
module test_onboard_flash_boot_loader;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int BIT = 48;

	logic                 pclk = 1'b0;
	logic                 presetn, psel, penable, pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic                 pready, pslverr, se, rxl, txl, ok, txoe_n;
	obfl_pkg::obfl_mode_t mode_pins;
	logic                 wdt_overflow_rst, flash_blank, flash_erase_done, flash_erase_all;
	obfl_pkg::obfl_ram_t  ram_wr;
	obfl_pkg::obfl_ram_t  wq[$];
	logic                 boot_rsv_protect, branch_go, boot_mode, user_program_mode;
	logic                 single_chip, prog_enable, erase_enable, flash_read_block, irq_block;
	logic [23:0]          branch_addr;
	logic [7:0]           b;
	logic [7:0]           img[3] = '{8'ha5, 8'h3c, 8'hff};
	int                   miscompares = 0;
	int                   n_tests = 0;
	int                   nbr = 0;
	int                   n;

	// Clock at 40 MHz
	always #12.5 pclk = ~pclk;

	obfl_boot dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .mode_pins, .serial_receive_pin(rxl), .serial_transmit_pin(txl),
		.serial_transmit_oe_n(txoe_n), .wdt_overflow_rst, .flash_blank, .flash_erase_done,
		.flash_erase_all, .ram_wr, .boot_rsv_protect, .branch_go, .branch_addr, .boot_mode,
		.user_program_mode, .single_chip, .prog_enable, .erase_enable, .flash_read_block,
		.irq_block
	);

	obfl_host_model #(.BIT_CYC(BIT)) h (.pclk, .from_dev(txl), .to_dev(rxl));

	// Log RAM writes and branch pulses as they happen
	always @(posedge pclk)
	begin
		if (ram_wr.we === 1'b1)
			wq.push_back(ram_wr);
		if (branch_go === 1'b1)
			nbr++;
	end

	task automatic test_done;
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Setup then access; an idle edge after release avoids a double drive
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the hang guard ends a wait on a silent slave
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask : wait_cyc

	// Hang guard, well beyond the few thousand cycles the run needs
	initial
	begin
		wait_cyc(60000);
		miscompares++;
		test_done;
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{wdt_overflow_rst, flash_blank, flash_erase_done} = '0;
		mode_pins = 4'b1011;
		wait_cyc(5);
		chk(32'(txl), 32'h1);
		presetn <= 1'b1;
		wait_cyc(4);
		chk(32'({boot_mode, user_program_mode, single_chip, boot_rsv_protect}), 32'hb);
		apb(1'b0, `OBFL_A_LEN, 32'h0);
		chk(rd, 32'h1780);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0);
		chk(32'(se), 32'h1);
		apb(1'b1, `OBFL_A_LEN, 32'h3);
		wait_cyc(120);
		h.adjust(b, ok);
		chk(32'({ok, b}), 32'h100);
		apb(1'b0, `OBFL_A_BAUD, 32'h0);
		chk(32'(rd inside {[BIT - 1:BIT]}), 32'h1);
		n = 0;
		while (flash_erase_all !== 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		chk(32'({flash_erase_all, irq_block, boot_rsv_protect}), 32'h7);
		flash_erase_done <= 1'b1;
		@(posedge pclk);
		flash_erase_done <= 1'b0;
		foreach (img[i])
			h.send(img[i]);
		wait_cyc(200);
		chk(32'(nbr), 32'h1);
		chk(32'(wq.size()), 32'h3);
		foreach (wq[i])
			chk(32'({wq[i].addr, wq[i].data}), {`OBFL_LOAD_BASE + 24'(i), img[i]});
		chk(32'(branch_addr), 32'(`OBFL_LOAD_BASE));
		chk(32'({txl, boot_rsv_protect}), 32'h2);
		chk(32'(txoe_n), 32'h0);
		b = rd[7:0];
		apb(1'b0, `OBFL_A_BAUD, 32'h0);
		chk(rd, 32'(b));
		wdt_overflow_rst <= 1'b1;
		@(posedge pclk);
		wdt_overflow_rst <= 1'b0;
		wait_cyc(3);
		chk(32'(boot_mode), 32'h0);
		// User program mode for both strap settings of the last mode pin
		for (int m = 0; m < 2; m++)
		begin
			presetn <= 1'b0;
			mode_pins <= {3'b111, 1'(m)};
			wait_cyc(20);
			presetn <= 1'b1;
			wait_cyc(110);
			apb(1'b0, `OBFL_A_STAT, 32'h0);
			chk(rd, {20'h0, 4'ha, 4'h0, 1'(m), 3'b101});
			chk(32'({txl, boot_rsv_protect, flash_erase_all}), 32'h4);
			apb(1'b1, `OBFL_A_CTRL, 32'h3);
			chk(32'({prog_enable, flash_read_block}), 32'h3);
			mode_pins.flash_write_enable_pin <= 1'b0;
			apb(1'b1, `OBFL_A_CTRL, 32'h5);
			wait_cyc(3);
			chk(32'({prog_enable, erase_enable}), 32'h0);
		end
		test_done;
	end
endmodule : test_onboard_flash_boot_loader
